// ==== rtl/adcsq_regs.svh ====
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH
`define ADCSQ_CSR_OFF 8'h45
`define ADCSQ_RESH_OFF 8'h46
`define ADCSQ_RESL_OFF 8'h47
`define ADCSQ_CSR_RESET 8'h00
`define ADCSQ_BIT_DONE 7
`define ADCSQ_BIT_SPEED 6
`define ADCSQ_BIT_ON 5
`define ADCSQ_BIT_SLOW 4
`define ADCSQ_CONV_BITS 10
`define ADCSQ_FULL_SCALE 10'h3ff
`define ADCSQ_ZERO_CODE 10'h000
`define ADCSQ_CONV_WINDOW 60
`endif

// ==== rtl/adcsq_pkg.sv ====
package adcsq_pkg;
  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_SAMPLE, ADCSQ_CONVERT} adcsq_state_t;
  typedef enum logic [1:0] {ADCSQ_DIV2, ADCSQ_DIV1, ADCSQ_DIV4, ADCSQ_DIV2B} adcsq_clksel_t;
endpackage : adcsq_pkg

// ==== rtl/adcsq_clkdiv.sv ====
`timescale 1ns/1ps
module adcsq_clkdiv
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire adcsq_pkg::adcsq_clksel_t sel_i,
  output logic tick_o
);
  logic [1:0] cnt_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  end
  // converter clock as enable pulse, a true clock would add a domain
  always_comb
  begin
    unique case (sel_i)
      adcsq_pkg::ADCSQ_DIV1: tick_o = run_i;
      adcsq_pkg::ADCSQ_DIV4: tick_o = run_i && (cnt_r == 2'h3);
      adcsq_pkg::ADCSQ_DIV2, adcsq_pkg::ADCSQ_DIV2B: tick_o = run_i && cnt_r[0];
    endcase
  end
endmodule : adcsq_clkdiv

// ==== rtl/adcsq_sar.sv ====
`timescale 1ns/1ps
`include "adcsq_regs.svh"
module adcsq_sar
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic tick_i,
  input wire logic cmp_i,
  output logic [9:0] trial_o,
  output logic done_o,
  output logic [9:0] code_o
);
  adcsq_pkg::adcsq_state_t state_r;
  logic [9:0] bit_r;
  logic [9:0] acc_r;
  assign trial_o = acc_r | bit_r;
  // binary search keeps code monotonic in input; cmp_i high above ref clamps to 3ff, low clamps to 0
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (rst_i || restart_i)
    begin
      state_r <= adcsq_pkg::ADCSQ_IDLE;
      bit_r <= 10'h200;
      acc_r <= 10'h000;
      code_o <= 10'h000;
    end
    else if (tick_i)
    begin
      unique case (state_r)
        adcsq_pkg::ADCSQ_IDLE: state_r <= adcsq_pkg::ADCSQ_SAMPLE;
        adcsq_pkg::ADCSQ_SAMPLE:
        begin
          state_r <= adcsq_pkg::ADCSQ_CONVERT;
          bit_r <= 10'h200;
          acc_r <= 10'h000;
        end
        adcsq_pkg::ADCSQ_CONVERT:
        begin
          if (bit_r == 10'h001)
          begin
            code_o <= cmp_i ? (acc_r | bit_r) : acc_r;
            done_o <= 1'b1;
            state_r <= adcsq_pkg::ADCSQ_SAMPLE;
          end
          else
          begin
            if (cmp_i)
              acc_r <= acc_r | bit_r;
            bit_r <= bit_r >> 1;
          end
        end
        default: state_r <= adcsq_pkg::ADCSQ_IDLE;
      endcase
    end
  end
endmodule : adcsq_sar

// ==== rtl/adcsq_top.sv ====
// Function
// - overrange input gives code ff/03
// - underrange input gives code zero
// - converter_on starts continuous conversions
// - clearing converter_on stops conversion
// - done sets flag, stores split result
// - reading result_high clears done flag
// - any status write clears done flag
// - channel change restarts, clears flag
// - reading result_low locks results
// - result_high read or off unlocks
// - locked results are not overwritten
// - slow/speed bits pick converter clock
// - channel_select drives input mux index
// - status register bit layout
// - status resets zero, bit7 read-only
// - halt disables converter, wait doesn't
// - results monotonic with input
// - result_low upper bits zero, read-only
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "adcsq_regs.svh"
module adcsq_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [7:0] dat_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  input wire logic halt_i,
  input wire logic cmp_i,
  output logic [3:0] analog_input_pin_o,
  output logic [9:0] trial_o,
  output logic sample_o
);
  logic [7:0] csr_r;
  logic [6:0] ctl_r;
  logic done_r;
  adcsq_pkg::adcsq_clksel_t clk_sel;
  logic [9:0] res_r;
  logic lock_r;
  logic ack_r;
  logic done_pulse;
  logic [9:0] code;
  logic tick;
  logic run;
  logic restart;
  logic req;
  logic wr_csr;
  logic rd_high;
  logic rd_low;
  logic chan_chg;
  logic [7:0] rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign req = cyc_i && stb_i && !ack_r;
  assign wr_csr = req && we_i && hit(adr_i, `ADCSQ_CSR_OFF);
  assign rd_high = req && !we_i && hit(adr_i, `ADCSQ_RESH_OFF);
  assign rd_low = req && !we_i && hit(adr_i, `ADCSQ_RESL_OFF);
  assign chan_chg = wr_csr && (dat_i[3:0] != csr_r[3:0]);
  // halt gates the converter off, wait has no input here at all
  assign run = csr_r[`ADCSQ_BIT_ON] && !halt_i;
  assign restart = !run || chan_chg;
  assign analog_input_pin_o = csr_r[3:0];
  assign sample_o = run;
  // status view: hardware flag over the software bits, each with one driver
  assign csr_r = {done_r, ctl_r};
  assign clk_sel = adcsq_pkg::adcsq_clksel_t'({ctl_r[`ADCSQ_BIT_SLOW], ctl_r[`ADCSQ_BIT_SPEED]});

  adcsq_clkdiv u_div
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run && !chan_chg),
    .sel_i(clk_sel),
    .tick_o(tick)
  );

  adcsq_sar u_sar
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart),
    .tick_i(tick),
    .cmp_i(cmp_i),
    .trial_o(trial_o),
    .done_o(done_pulse),
    .code_o(code)
  );

  // control bits; bit 7 is hardware-owned
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctl_r <= 7'h00;
    else if (wr_csr)
      ctl_r <= dat_i[6:0];
  end

  // done flag: set beats clear; a completion while locked or on a channel change is dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_r <= 1'b0;
    else if (done_pulse && !lock_r && !chan_chg)
      done_r <= 1'b1;
    else if (wr_csr || rd_high)
      done_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || rd_high || !csr_r[`ADCSQ_BIT_ON])
      lock_r <= 1'b0;
    else if (rd_low)
      lock_r <= 1'b1;
  end

  // comparator clamps make out-of-range inputs land on 3ff or 000
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      res_r <= `ADCSQ_ZERO_CODE;
    else if (done_pulse && !lock_r && !chan_chg)
      res_r <= code;
  end

  always_comb
  begin
    rdata = 8'h00;
    if (hit(adr_i, `ADCSQ_CSR_OFF))
      rdata = csr_r;
    else if (hit(adr_i, `ADCSQ_RESH_OFF))
      rdata = res_r[9:2];
    else if (hit(adr_i, `ADCSQ_RESL_OFF))
      rdata = {6'h00, res_r[1:0]};
  end

  // one-cycle answer; unmapped reads give zero, writes ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_o <= 8'h00;
    end
    else
    begin
      ack_r <= req;
      if (req && !we_i)
        dat_o <= rdata;
    end
  end
  assign ack_o = ack_r;

  chk_done_clear_hr: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_high && !(done_pulse && !lock_r) |=> !csr_r[`ADCSQ_BIT_DONE])
    else $error("done flag not cleared by high read");
  chk_done_clear_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_csr && !(done_pulse && !lock_r && !chan_chg) |=> !csr_r[`ADCSQ_BIT_DONE])
    else $error("done flag not cleared by write");
  chk_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_r && !rd_high && csr_r[`ADCSQ_BIT_ON] |=> $stable(res_r))
    else $error("result changed while locked");
  chk_lock_set: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_low && !rd_high && csr_r[`ADCSQ_BIT_ON] |=> lock_r)
    else $error("low read did not lock");
  chk_lock_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !csr_r[`ADCSQ_BIT_ON] |=> !lock_r)
    else $error("lock held while off");
  chk_done_set: assert property (@(posedge clk_i) disable iff (rst_i)
    done_pulse && !lock_r && !chan_chg |=> csr_r[`ADCSQ_BIT_DONE] && res_r == $past(code))
    else $error("completion not recorded");
  chk_off_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !run |-> !tick ##1 !done_pulse)
    else $error("converter runs while off");
  chk_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_r && $past(rd_low) |-> dat_o[7:2] == 6'h00)
    else $error("low result upper bits nonzero");
  chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o ##1 !ack_o)
    else $error("bus answer not single cycle");

  // assertion helpers; the bound covers a first conversion at the slowest clock
  localparam int CONV_WINDOW = `ADCSQ_CONV_WINDOW;
  logic rd_other;
  logic div2_sel;
  logic div4_sel;
  assign rd_other = req && !we_i && !hit(adr_i, `ADCSQ_CSR_OFF) && !hit(adr_i, `ADCSQ_RESH_OFF)
    && !hit(adr_i, `ADCSQ_RESL_OFF);
  assign div2_sel = (clk_sel == adcsq_pkg::ADCSQ_DIV2) || (clk_sel == adcsq_pkg::ADCSQ_DIV2B);
  assign div4_sel = (clk_sel == adcsq_pkg::ADCSQ_DIV4);

  sequence s_restart_quiet;
    !csr_r[`ADCSQ_BIT_DONE] && !done_pulse ##1 !done_pulse;
  endsequence : s_restart_quiet

  sequence s_div4_quiet;
    (!tick || !div4_sel) [*3];
  endsequence : s_div4_quiet

  property p_reset_state;
    @(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> csr_r == `ADCSQ_CSR_RESET && res_r == `ADCSQ_ZERO_CODE && !lock_r && !ack_o;
  endproperty : p_reset_state
  chk_reset_state: assert property (p_reset_state)
    else $error("state not cleared by reset");

  property p_ctl_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_csr |=> ctl_r == 7'($past(dat_i));
  endproperty : p_ctl_write
  chk_ctl_write: assert property (p_ctl_write)
    else $error("control bits not written");

  property p_pin_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_csr |=> analog_input_pin_o == 4'($past(dat_i));
  endproperty : p_pin_write
  chk_pin_write: assert property (p_pin_write)
    else $error("channel index not routed");

  property p_done_by_hw;
    @(posedge clk_i) disable iff (rst_i)
    $rose(done_r) |-> $past(done_pulse) && !$past(lock_r);
  endproperty : p_done_by_hw
  chk_done_hw_only: assert property (p_done_by_hw)
    else $error("done flag set without completion");

  property p_chan_restart;
    @(posedge clk_i) disable iff (rst_i)
    chan_chg |=> s_restart_quiet;
  endproperty : p_chan_restart
  chk_chan_restart: assert property (p_chan_restart)
    else $error("channel change did not restart");

  property p_high_data;
    @(posedge clk_i) disable iff (rst_i)
    rd_high |=> dat_o == 8'($past(res_r) >> 2);
  endproperty : p_high_data
  chk_high_data: assert property (p_high_data)
    else $error("high result bits wrong");

  property p_low_data;
    @(posedge clk_i) disable iff (rst_i)
    rd_low |=> dat_o == {6'h00, 2'($past(res_r))};
  endproperty : p_low_data
  chk_low_data: assert property (p_low_data)
    else $error("low result bits wrong");

  property p_high_unlock;
    @(posedge clk_i) disable iff (rst_i)
    rd_high |=> !lock_r;
  endproperty : p_high_unlock
  chk_high_unlock: assert property (p_high_unlock)
    else $error("high read did not unlock");

  property p_div1_rate;
    @(posedge clk_i) disable iff (rst_i)
    clk_sel == adcsq_pkg::ADCSQ_DIV1 && run && !chan_chg |-> tick;
  endproperty : p_div1_rate
  chk_div1_rate: assert property (p_div1_rate)
    else $error("full rate clock missed a tick");

  property p_div_gap;
    @(posedge clk_i) disable iff (rst_i)
    tick && clk_sel != adcsq_pkg::ADCSQ_DIV1 |=> !tick || clk_sel == adcsq_pkg::ADCSQ_DIV1;
  endproperty : p_div_gap
  chk_div_gap: assert property (p_div_gap)
    else $error("divided clock ticked twice in a row");

  property p_div2_rate;
    @(posedge clk_i) disable iff (rst_i)
    div2_sel && run && !chan_chg |-> ##[0:1] (tick || !run || chan_chg || !div2_sel);
  endproperty : p_div2_rate
  chk_div2_rate: assert property (p_div2_rate)
    else $error("half rate clock too slow");

  property p_div4_gap;
    @(posedge clk_i) disable iff (rst_i)
    div4_sel && tick |=> s_div4_quiet;
  endproperty : p_div4_gap
  chk_div4_gap: assert property (p_div4_gap)
    else $error("quarter rate clock too fast");

  property p_div4_rate;
    @(posedge clk_i) disable iff (rst_i)
    div4_sel && run && !chan_chg |-> ##[0:3] (tick || !run || chan_chg || !div4_sel);
  endproperty : p_div4_rate
  chk_div4_rate: assert property (p_div4_rate)
    else $error("quarter rate clock too slow");

  property p_conv_bound;
    @(posedge clk_i) disable iff (rst_i)
    run |-> ##[0:CONV_WINDOW] (done_pulse || !run || chan_chg);
  endproperty : p_conv_bound
  chk_conv_bound: assert property (p_conv_bound)
    else $error("conversion did not complete while on");

  property p_halt_stop;
    @(posedge clk_i) disable iff (rst_i)
    halt_i |-> !sample_o && !tick;
  endproperty : p_halt_stop
  chk_halt_stop: assert property (p_halt_stop)
    else $error("converter runs during halt");

  property p_unmapped_zero;
    @(posedge clk_i) disable iff (rst_i)
    rd_other |=> dat_o == 8'h00;
  endproperty : p_unmapped_zero
  chk_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_result_ro;
    @(posedge clk_i) disable iff (rst_i)
    req && we_i && !hit(adr_i, `ADCSQ_CSR_OFF) && !done_pulse |=> $stable(res_r);
  endproperty : p_result_ro
  chk_result_ro: assert property (p_result_ro)
    else $error("result changed by a write");
endmodule : adcsq_top

// ==== verif/adcsq_top_tb_top.sv ====
`timescale 1ns/1ps
module adcsq_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic halt_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [7:0] dat_i = 8'h00;
  logic [7:0] dat_o;
  logic [7:0] rd;
  logic ack_o;
  logic sample_o;
  logic [3:0] pin;
  logic [9:0] trial_o;
  logic [9:0] tgt = 10'h000;
  logic cmp_i;
  int n_fail = 0;
  int num_checks = 0;
  int cyc_n = 0;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  // ideal input held at code tgt
  assign cmp_i = (trial_o <= tgt);
  adcsq_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .halt_i(halt_i), .cmp_i(cmp_i),
    .analog_input_pin_o(pin), .trial_o(trial_o), .sample_o(sample_o));
  task automatic conclude;
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 20);
    rd = dat_o;
    if (k >= 20)
      chk({9'h0, ack_o}, 10'h001);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk({2'h0, rd}, {2'h0, e});
  endtask : rc
  task automatic wait_done;
    int k;
    k = 0;
    rd = 8'h00;
    while (rd[7] !== 1'b1 && k < 100)
    begin
      wb(1'b0, 8'h45, 8'h00);
      k++;
    end
    chk({9'h0, rd[7]}, 10'h001);
  endtask : wait_done
  task automatic t_reset;
    rc(8'h45, 8'h00);
    rc(8'h46, 8'h00);
    rc(8'h47, 8'h00);
    wb(1'b1, 8'h46, 8'hff);
    wb(1'b1, 8'h47, 8'hff);
    wb(1'b1, 8'h33, 8'hff);
    rc(8'h46, 8'h00);
    rc(8'h47, 8'h00);
    rc(8'h33, 8'h00);
    wb(1'b1, 8'h45, 8'hdf);
    rc(8'h45, 8'h5f);
    chk({6'h0, pin}, 10'h00f);
  endtask : t_reset
  task automatic t_speed;
    logic [9:0] codes [4] = '{10'h3ff, 10'h000, 10'h2a5, 10'h15a};
    int divs [4] = '{2, 1, 4, 2};
    int t0;
    int dt;
    for (int s = 0; s < 4; s++)
    begin
      tgt = codes[s];
      wb(1'b1, 8'h45, 8'h00);
      t0 = cyc_n;
      wb(1'b1, 8'h45, {1'b0, s[0], 1'b1, s[1], 4'h2});
      wait_done;
      dt = cyc_n - t0;
      chk({9'h0, dt >= 12 * divs[s] && dt <= 12 * divs[s] + 10}, 10'h001);
      rc(8'h47, {6'h0, codes[s][1:0]});
      rc(8'h46, codes[s][9:2]);
    end
  endtask : t_speed
  task automatic t_lock;
    wb(1'b1, 8'h45, 8'h00);
    tgt = 10'h2a5;
    wb(1'b1, 8'h45, 8'h23);
    wait_done;
    rc(8'h47, 8'h01);
    tgt = 10'h15a;
    repeat (80) @(posedge clk_i);
    rc(8'h47, 8'h01);
    rc(8'h46, 8'ha9);
    rc(8'h45, 8'h23);
    wait_done;
    rc(8'h46, 8'h56);
    wait_done;
    wb(1'b1, 8'h45, 8'h23);
    rc(8'h45, 8'h23);
    wait_done;
    wb(1'b1, 8'h45, 8'h27);
    rc(8'h45, 8'h27);
    chk({6'h0, pin}, 10'h007);
    wait_done;
    rc(8'h47, 8'h02);
    tgt = 10'h2a5;
    wb(1'b1, 8'h45, 8'h07);
    wb(1'b1, 8'h45, 8'h27);
    wait_done;
    rc(8'h47, 8'h01);
    rc(8'h46, 8'ha9);
  endtask : t_lock
  task automatic t_off;
    wb(1'b1, 8'h45, 8'h07);
    chk({9'h0, sample_o}, 10'h000);
    repeat (60) @(posedge clk_i);
    rc(8'h45, 8'h07);
    wb(1'b1, 8'h45, 8'h27);
    halt_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({9'h0, sample_o}, 10'h000);
    repeat (60) @(posedge clk_i);
    rc(8'h45, 8'h27);
    halt_i <= 1'b0;
    wait_done;
  endtask : t_off
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_speed;
    t_lock;
    t_off;
    conclude;
  end
  // whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    conclude;
  end
endmodule : adcsq_top_tb_top
